// *** tmie_regs.svh ***
// register map, field positions and reset values for the timer flag block
// assumes a 32-bit apb slave where each register takes one aligned word
// Summary of operation
// - capture C request only while enable bit 5 is one.
// - capture D request when flag D set and enable bit 4 one.
// - compare A request when flag A set and enable bit 3 one.
// - compare B request when flag B set and enable bit 2 one.
// - wrap request when wrap flag set and enable bit 1 one.
// - enable bit 0 ignores writes and always reads as one.
// - flag and control register loads zero on reset and standby.
// - writing zero clears flags 7..1, writing one keeps them; only events set.
// - a zero write clears a flag only after it was read as one.
// - flag 7 sets on every capture A event.
// - flag 6 sets on every capture B event.
// - flag 5 sets on input C edge, even when pair A buffering.
// - flag 4 sets on input D edge, even when pair B buffering.
// - flag 3 sets when counter equals compare register A.
// - flag 2 sets when counter equals compare register B.
// - flag 1 sets when the counter wraps from maximum to zero.
// - control bit 0 one clears the counter on compare match A.
// - buffer enable A stops input C capture; B likewise stops D.
// - enable register resets to all enables zero, bit 0 one.
`ifndef TMIE_REGS_SVH
`define TMIE_REGS_SVH

// printed offsets are register indices; byte address is four times that
`define TMIE_IDX_ENABLES   16'hff90
`define TMIE_IDX_FLAGS     16'hff91
`define TMIE_ADDR_ENABLES  32'h0003_fe40
`define TMIE_ADDR_FLAGS    32'h0003_fe44

// field positions; bits 7..1 shared by both registers, bit 0 clear-on-match A in flags only
`define TMIE_BIT_CAP_A     7
`define TMIE_BIT_CAP_B     6
`define TMIE_BIT_CAP_C     5
`define TMIE_BIT_CAP_D     4
`define TMIE_BIT_CMP_A     3
`define TMIE_BIT_CMP_B     2
`define TMIE_BIT_WRAP      1
`define TMIE_BIT_CLR_A     0

// reset values
`define TMIE_RST_FLAGS     8'h00
`define TMIE_RST_ENABLES   8'h01
`define TMIE_RSVD_ONE      1'b1

`endif

// *** tmie_pkg.sv ***
// types shared by the timer flag block
// assumes the register header supplies every number
package tmie_pkg;

    typedef logic [7:0]  tmie_byte_t;
    typedef logic [31:0] tmie_word_t;

    // apb answer sequencing
    typedef enum logic {
        TMIE_AP_IDLE,
        TMIE_AP_ANSWER
    } tmie_apb_e;

endpackage

// *** tmie_flags.sv ***
// timer interrupt enables, status flags and counter-clear control
// assumes event strobes come from logic on clk_sys, one cycle each
`timescale 1ns/100ps
`include "tmie_regs.svh"

module tmie_flags (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             standby,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire tmie_pkg::tmie_word_t paddr,
    input  wire tmie_pkg::tmie_word_t pwdata,
    output tmie_pkg::tmie_word_t  prdata,
    output logic                  pready,
    output logic                  pslverr,
    // timer events
    input  wire logic             cap_a_evt,
    input  wire logic             cap_b_evt,
    input  wire logic             cap_c_evt,
    input  wire logic             cap_d_evt,
    input  wire logic             cmp_a_match,
    input  wire logic             cmp_b_match,
    input  wire logic             wrap_evt,
    // buffering mode from the control register
    input  wire logic             buffer_pair_a_en,
    input  wire logic             buffer_pair_b_en,
    // capture steering and counter clear
    output logic                  cap_c_load,
    output logic                  cap_d_load,
    output logic                  counter_clear,
    output logic                  clear_on_match_a,
    // interrupt requests
    output logic                  cap_a_irq,
    output logic                  cap_b_irq,
    output logic                  cap_c_irq,
    output logic                  cap_d_irq,
    output logic                  cmp_a_irq,
    output logic                  cmp_b_irq,
    output logic                  wrap_irq
);
    import tmie_pkg::*;

    // state
    tmie_apb_e   ap_state;
    tmie_apb_e   next_ap_state;
    logic [7:1]  flag;
    logic [7:1]  next_flag;
    logic [7:1]  armed;
    logic [7:1]  next_armed;
    logic [7:1]  irq_en;
    logic [7:1]  next_irq_en;
    logic [7:1]  irq;
    logic        next_clr_a;

    // event vector in register bit order
    logic [7:1]  evt;

    // bus decode
    logic        acc_phase;
    logic        done;
    logic        hit_flags;
    logic        hit_enables;
    logic        hit_any;
    logic        wr_flags;
    logic        wr_enables;
    logic        rd_flags;
    logic        init;
    tmie_byte_t  flags_view;
    tmie_byte_t  enables_view;
    tmie_byte_t  rd_byte;

    // event gathering, one strobe per flag position
    // capture A sets 7
    assign evt[`TMIE_BIT_CAP_A] = cap_a_evt;
    assign evt[`TMIE_BIT_CAP_B] = cap_b_evt;
    assign evt[`TMIE_BIT_CAP_C] = cap_c_evt;
    assign evt[`TMIE_BIT_CAP_D] = cap_d_evt;
    assign evt[`TMIE_BIT_CMP_A] = cmp_a_match;
    assign evt[`TMIE_BIT_CMP_B] = cmp_b_match;
    assign evt[`TMIE_BIT_WRAP]  = wrap_evt;

    // standby behaves like reset for both registers
    assign init = sys_rst | standby;

    // apb decode; one wait state keeps prdata a flop
    assign acc_phase   = psel & penable;
    assign done        = acc_phase & pready;
    assign hit_flags   = (paddr == `TMIE_ADDR_FLAGS);
    assign hit_enables = (paddr == `TMIE_ADDR_ENABLES);
    assign hit_any     = hit_flags | hit_enables;
    assign wr_flags    = done & pwrite & hit_flags;
    assign wr_enables  = done & pwrite & hit_enables;
    assign rd_flags    = done & ~pwrite & hit_flags;

    // register views as software sees them
    assign flags_view   = {flag, clear_on_match_a};
    assign enables_view = {irq_en, `TMIE_RSVD_ONE};
    assign rd_byte      = hit_flags ? flags_view
                        : hit_enables ? enables_view
                        : 8'h00;

    // answer sequencing
    always_comb begin
        next_ap_state = ap_state;
        case (ap_state)
            TMIE_AP_IDLE: begin
                if (acc_phase) begin
                    next_ap_state = TMIE_AP_ANSWER;
                end
            end
            TMIE_AP_ANSWER: begin
                next_ap_state = TMIE_AP_IDLE;
            end
            default: begin
                next_ap_state = TMIE_AP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ap_state <= TMIE_AP_IDLE;
        end else begin
            ap_state <= next_ap_state;
        end
    end

    // answer outputs, registered so they come straight from flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= (next_ap_state == TMIE_AP_ANSWER);
            pslverr <= (next_ap_state == TMIE_AP_ANSWER) & ~hit_any;
            prdata  <= {24'h00_0000, rd_byte};
        end
    end

    // per-flag set, read-arm and clear logic
    genvar gi;
    generate
        for (gi = 1; gi <= 7; gi++) begin : g_flag
            logic sw_clear;
            // zero write honoured only once armed
            assign sw_clear = wr_flags & ~pwdata[gi] & armed[gi];
            // set beats clear; writing one keeps the flag
            assign next_flag[gi] = init ? 1'b0
                                 : evt[gi] | (flag[gi] & ~sw_clear);
            // arm on a read that saw the flag set
            // prdata holds what software reads; a flag that rose during the
            // wait state was never seen, so it must not arm
            assign next_armed[gi] = init ? 1'b0
                                  : (rd_flags & prdata[gi]) ? 1'b1
                                  : (wr_flags | ~flag[gi]) ? 1'b0
                                  : armed[gi];
            // enable writes land only in bits 7..1
            assign next_irq_en[gi] = init ? 1'b0
                                   : wr_enables ? pwdata[gi]
                                   : irq_en[gi];
        end
    endgenerate

    assign next_clr_a = init ? 1'b0
                      : wr_flags ? pwdata[`TMIE_BIT_CLR_A]
                      : clear_on_match_a;

    // flags and control bit zero on reset and standby
    always_ff @(posedge clk_sys) begin
        flag             <= next_flag;
        armed            <= next_armed;
        clear_on_match_a <= next_clr_a;
    end

    // enables zero on reset and standby
    always_ff @(posedge clk_sys) begin
        irq_en <= next_irq_en;
    end

    // request level tracks flag and enable in the same cycle
    always_ff @(posedge clk_sys) begin
        irq <= next_flag & next_irq_en;
    end

    // request outputs, one per source
    assign cap_a_irq = irq[`TMIE_BIT_CAP_A];
    assign cap_b_irq = irq[`TMIE_BIT_CAP_B];
    // capture C request gated by bit 5
    assign cap_c_irq = irq[`TMIE_BIT_CAP_C];
    // capture D request gated by bit 4
    assign cap_d_irq = irq[`TMIE_BIT_CAP_D];
    // compare A request gated by bit 3
    assign cmp_a_irq = irq[`TMIE_BIT_CMP_A];
    // compare B request gated by bit 2
    assign cmp_b_irq = irq[`TMIE_BIT_CMP_B];
    // wrap request gated by bit 1
    assign wrap_irq  = irq[`TMIE_BIT_WRAP];

    // capture steering and counter clear, one cycle after the event
    // the counter side sees a late clear; it must apply it as a pulse
    always_ff @(posedge clk_sys) begin
        if (init) begin
            cap_c_load    <= 1'b0;
            cap_d_load    <= 1'b0;
            counter_clear <= 1'b0;
        end else begin
            // buffering frees inputs C and D from capture
            cap_c_load    <= cap_c_evt & ~buffer_pair_a_en;
            cap_d_load    <= cap_d_evt & ~buffer_pair_b_en;
            // clear counter on match A when enabled
            counter_clear <= cmp_a_match & clear_on_match_a;
        end
    end

    // checks on the flag and request behaviour

    // capture A sets flag 7 by the next edge
    a_cap_a_sets: assert property (@(posedge clk_sys) disable iff (init)
        cap_a_evt |=> flag[`TMIE_BIT_CAP_A])
        else $error("capture A event did not set flag 7");

    a_cap_b_sets: assert property (@(posedge clk_sys) disable iff (init)
        cap_b_evt |=> flag[`TMIE_BIT_CAP_B])
        else $error("capture B event did not set flag 6");

    // input C in buffer mode sets flag 5 without a capture load
    a_cap_c_sets: assert property (@(posedge clk_sys) disable iff (init)
        cap_c_evt && buffer_pair_a_en |=> flag[`TMIE_BIT_CAP_C] && !cap_c_load)
        else $error("input C in buffer mode mishandled");

    // input D sets flag 4 and captures when unbuffered
    a_cap_d_sets: assert property (@(posedge clk_sys) disable iff (init)
        cap_d_evt && !buffer_pair_b_en |=> flag[`TMIE_BIT_CAP_D] && cap_d_load)
        else $error("input D unbuffered capture missing");

    a_cmp_a_sets: assert property (@(posedge clk_sys) disable iff (init)
        cmp_a_match |=> flag[`TMIE_BIT_CMP_A])
        else $error("match A did not set flag 3");

    a_cmp_b_sets: assert property (@(posedge clk_sys) disable iff (init)
        cmp_b_match |=> flag[`TMIE_BIT_CMP_B])
        else $error("match B did not set flag 2");

    a_wrap_sets: assert property (@(posedge clk_sys) disable iff (init)
        wrap_evt |=> flag[`TMIE_BIT_WRAP])
        else $error("wrap did not set flag 1");

    // flag 3 never rises without its match A event
    a_flag_no_sw_set: assert property (@(posedge clk_sys) disable iff (init)
        !flag[`TMIE_BIT_CMP_A] && !cmp_a_match |=> !flag[`TMIE_BIT_CMP_A])
        else $error("flag 3 rose without a match");

    // unarmed zero write leaves the flag set
    a_clear_needs_read: assert property (@(posedge clk_sys) disable iff (init)
        wr_flags && flag[`TMIE_BIT_WRAP] && !armed[`TMIE_BIT_WRAP]
        |=> flag[`TMIE_BIT_WRAP])
        else $error("flag 1 cleared without a prior read");

    // armed zero write clears within one edge
    a_clear_after_read: assert property (@(posedge clk_sys) disable iff (init)
        wr_flags && armed[`TMIE_BIT_CMP_B] && !pwdata[`TMIE_BIT_CMP_B] && !cmp_b_match
        |=> !flag[`TMIE_BIT_CMP_B])
        else $error("armed zero write did not clear flag 2");

    // capture C request follows flag and bit 5
    a_cap_c_req: assert property (@(posedge clk_sys) disable iff (init)
        cap_c_irq == (flag[`TMIE_BIT_CAP_C] && irq_en[`TMIE_BIT_CAP_C]))
        else $error("capture C request wrong");

    // capture D request follows flag and bit 4
    a_cap_d_req: assert property (@(posedge clk_sys) disable iff (init)
        cap_d_irq == (flag[`TMIE_BIT_CAP_D] && irq_en[`TMIE_BIT_CAP_D]))
        else $error("capture D request wrong");

    // compare A request disabled by bit 3
    a_cmp_a_req: assert property (@(posedge clk_sys) disable iff (init)
        !irq_en[`TMIE_BIT_CMP_A] |-> !cmp_a_irq)
        else $error("compare A request while disabled");

    // compare B request follows a set flag
    a_cmp_b_req: assert property (@(posedge clk_sys) disable iff (init)
        cmp_b_match && irq_en[`TMIE_BIT_CMP_B] && !wr_enables |=> cmp_b_irq)
        else $error("compare B request missing");

    // wrap request held while flag and enable stay
    a_wrap_req: assert property (@(posedge clk_sys) disable iff (init)
        wrap_irq && !wr_flags && !wr_enables |=> wrap_irq)
        else $error("wrap request dropped early");

    // request level stays until the flag or its enable goes
    a_req_level: assert property (@(posedge clk_sys) disable iff (init)
        $fell(cap_a_irq) |-> !flag[`TMIE_BIT_CAP_A] || !irq_en[`TMIE_BIT_CAP_A])
        else $error("capture A request fell with flag set");

    a_rsvd_one: assert property (@(posedge clk_sys) disable iff (init)
        done && !pwrite && hit_enables |-> prdata[0])
        else $error("reserved enable bit read as zero");

    a_standby_zero: assert property (@(posedge clk_sys)
        standby && !sys_rst |=> flags_view == `TMIE_RST_FLAGS)
        else $error("flags not zero after standby");

    // standby sets the enable view to its reset value
    a_standby_en: assert property (@(posedge clk_sys)
        standby |=> enables_view == `TMIE_RST_ENABLES)
        else $error("enables not at reset value after standby");

    // counter clear follows match A only when enabled
    a_clear_match: assert property (@(posedge clk_sys) disable iff (init)
        cmp_a_match |=> counter_clear == $past(clear_on_match_a))
        else $error("counter clear does not follow control bit");

    // buffer A blocks capture C loads
    a_buf_blocks_c: assert property (@(posedge clk_sys) disable iff (init)
        buffer_pair_a_en ##1 buffer_pair_a_en |-> !cap_c_load)
        else $error("input C captured in buffer mode");

    // apb answers in exactly one wait state
    a_apb_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule

// *** tmie_cpu_model.sv ***
// cpu model: apb master standing on the register side of the timer flag block
// assumes one clock and a slave that raises pready sooner or later; the model keeps no cycle limit
`timescale 1ns/100ps

module tmie_cpu_model (
    // clock
    input  wire logic                 clk_sys,
    // apb master
    output logic                      psel,
    output logic                      penable,
    output logic                      pwrite,
    output tmie_pkg::tmie_word_t      paddr,
    output tmie_pkg::tmie_word_t      pwdata,
    input  wire tmie_pkg::tmie_word_t prdata,
    input  wire logic                 pready,
    input  wire logic                 pslverr
);
    import tmie_pkg::*;

    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // one transfer; everything held until pready is sampled high at an edge
    task automatic xfer(input logic wr, input tmie_word_t addr, input tmie_word_t data,
                        output tmie_word_t rdata, output logic err, output logic ok);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        ok = (pready === 1'b1);
        rdata = prdata;
        err = pslverr;
        // released lines flip so a stale value never passes for data
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~addr;
        pwdata  <= ~data;
    endtask
endmodule

// *** test_tmie_flags.sv ***
// self-checking bench for the timer flag, enable and counter-clear block
// assumes the cpu model drives apb; this bench drives events, modes and standby
`timescale 1ns/100ps
`include "tmie_regs.svh"

module test_tmie_flags;
    import tmie_pkg::*;

    logic       clk_sys, sys_rst, standby, buffer_pair_a_en, buffer_pair_b_en;
    logic [7:0] evt;
    logic       psel, penable, pwrite, pready, pslverr;
    tmie_word_t paddr, pwdata, prdata;
    logic       cap_c_load, cap_d_load, counter_clear, clear_on_match_a;
    logic       cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq, cmp_a_irq, cmp_b_irq, wrap_irq;
    int         n_fail, samples_checked, m_flags, m_en, m_arm, m_clr, b;
    tmie_word_t addrs [4];

    tmie_flags i_tmie_flags (
        .clk_sys, .sys_rst, .standby, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cap_a_evt(evt[7]), .cap_b_evt(evt[6]), .cap_c_evt(evt[5]), .cap_d_evt(evt[4]),
        .cmp_a_match(evt[3]), .cmp_b_match(evt[2]), .wrap_evt(evt[1]),
        .buffer_pair_a_en, .buffer_pair_b_en, .cap_c_load, .cap_d_load, .counter_clear, .clear_on_match_a,
        .cap_a_irq, .cap_b_irq, .cap_c_irq, .cap_d_irq, .cmp_a_irq, .cmp_b_irq, .wrap_irq
    );
    tmie_cpu_model cpu (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    // 20 mhz clock
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    // compare tasks, one per kind of result
    task automatic check_reg(input string what, input tmie_word_t exp, input tmie_word_t seen);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_line(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // outputs looked at mid-cycle, once the edge's updates have landed
    task automatic check_out(input logic [2:0] ld);
        @(negedge clk_sys);
        check_line("irq", 8'(m_flags & m_en & 8'hfe),
                   {cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq, cmp_a_irq, cmp_b_irq, wrap_irq, 1'b0});
        check_line("loads", {5'h0, ld}, {5'h0, cap_c_load, cap_d_load, counter_clear});
        check_line("clear_on_match_a", 8'(m_clr), {7'h0, clear_on_match_a});
    endtask

    // one register access, with the model updated at the edge where it lands
    task automatic reg_op(input logic wr, input tmie_word_t addr, input logic [7:0] d);
        tmie_word_t rd, exp;
        logic       err, ok, bad;
        cpu.xfer(wr, addr, {24'h0, d}, rd, err, ok);
        bad = (addr !== `TMIE_ADDR_FLAGS) && (addr !== `TMIE_ADDR_ENABLES);
        exp = '0;
        if (addr === `TMIE_ADDR_FLAGS) begin
            exp = 32'(m_flags | m_clr);
            if (wr) begin
                m_flags = m_flags & ~(m_arm & ~d);
                m_arm = 0;
                m_clr = d[0];
            end else begin
                m_arm = m_flags;
            end
        end else if (addr === `TMIE_ADDR_ENABLES) begin
            exp = 32'(m_en);
            if (wr) m_en = d | 8'h01;
        end
        check_reg("pready", 32'h1, {31'h0, ok});
        check_reg("pslverr", {31'h0, bad}, {31'h0, err});
        if (!wr) check_reg("prdata", exp, rd);
    endtask

    // one-cycle event strobes; flags bits 7..1 follow the event vector
    task automatic pulse(input int v);
        @(posedge clk_sys);
        evt <= 8'(v);
        @(posedge clk_sys);
        evt <= 8'h00;
        m_flags = m_flags | (v & 8'hfe);
        check_out({v[5] & !buffer_pair_a_en, v[4] & !buffer_pair_b_en, v[3] & m_clr[0]});
    endtask

    // verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        standby = 1'b0;
        buffer_pair_a_en = 1'b0;
        buffer_pair_b_en = 1'b0;
        evt = 8'h00;
        n_fail = 0;
        samples_checked = 0;
        m_flags = 0;
        m_en = 1;
        m_arm = 0;
        m_clr = 0;
        addrs = '{`TMIE_ADDR_ENABLES, `TMIE_ADDR_FLAGS, 32'h0003_fe48, 32'h0000_0000};
        void'($urandom(83));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_out(3'h0);
        reg_op(1'b0, `TMIE_ADDR_ENABLES, 8'h00);
        reg_op(1'b0, `TMIE_ADDR_FLAGS, 8'h00);
        reg_op(1'b1, `TMIE_ADDR_ENABLES, 8'h00);
        reg_op(1'b0, `TMIE_ADDR_ENABLES, 8'h00);
        // each source: gated request, refused clears, then read and clear
        for (b = 1; b < 8; b++) begin
            buffer_pair_a_en <= 1'($urandom_range(0, 1));
            buffer_pair_b_en <= 1'($urandom_range(0, 1));
            reg_op(1'b1, `TMIE_ADDR_FLAGS, {7'h7f, b[0]});
            reg_op(1'b1, `TMIE_ADDR_ENABLES, 8'($urandom() & ~(1 << b)));
            pulse(1 << b);
            reg_op(1'b1, `TMIE_ADDR_ENABLES, 8'hff);
            check_out(3'h0);
            reg_op(1'b1, `TMIE_ADDR_FLAGS, 8'h00);
            reg_op(1'b0, `TMIE_ADDR_FLAGS, 8'h00);
            reg_op(1'b1, `TMIE_ADDR_FLAGS, 8'hff);
            reg_op(1'b0, `TMIE_ADDR_FLAGS, 8'h00);
            reg_op(1'b1, `TMIE_ADDR_FLAGS, 8'h00);
            check_out(3'h0);
        end
        // random traffic mixing events, modes and accesses, unmapped ones too
        for (b = 0; b < 80; b++) begin
            buffer_pair_a_en <= 1'($urandom_range(0, 1));
            buffer_pair_b_en <= 1'($urandom_range(0, 1));
            if ($urandom_range(0, 1) == 1) pulse(int'($urandom_range(0, 255)));
            reg_op(1'($urandom_range(0, 1)), addrs[$urandom_range(0, 3)], 8'($urandom()));
            check_out(3'h0);
        end
        // standby entry reloads both registers
        pulse(8'hfe);
        @(posedge clk_sys);
        standby <= 1'b1;
        @(posedge clk_sys);
        standby <= 1'b0;
        m_flags = 0;
        m_en = 1;
        m_arm = 0;
        m_clr = 0;
        check_out(3'h0);
        reg_op(1'b0, `TMIE_ADDR_FLAGS, 8'h00);
        reg_op(1'b0, `TMIE_ADDR_ENABLES, 8'h00);
        final_report();
    end
endmodule
